// [design/rwc_pkg.sv]
// Overview of operation
// R1: Three reset causes; bus reset never resets CPU
// R2: Hardware reset restores defaults, address, interrupts
// R3: Hardware reset zeroes both stack pointers
// R4: Status register records cause in bits 4-6
// R5: Power-on or watchdog reset starts at zero
// R6: Reset entry pushes nothing onto stack
// R7: Firmware moves data stack below endpoint buffers
// R8: Power-on reset sets power-up flag
// R9: Power-on reset floats general-purpose pins
// R10: Strap high and idle bus parks in suspend
// R11: Suspend exit with strap high waits 128 us
// R12: Strap low waits 96 ms then runs
// R13: Delay picked from strap then power-up flag
// R14: Firmware clears power-up flag before suspend
// R15: Watchdog upper bit rising fires watchdog reset
// R16: Watchdog advances once per timer bit 11 period
// R17: Any write to 0x26 clears watchdog
// R18: Watchdog reset held 2.048 ms, then address zero
// R19: Transmitter off until address-enable bit set
// R20: Long SE0 flags bus reset, raises interrupt
// R21: Power-on loads status with 00010001
// R22: Watchdog reset loads status with 01000001
// R23: Detector and strap synchronised before use
package rwc_pkg;

   // ---------------------------------------------------------
   // Timing
   // ---------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned T_SETTLE_US = 128;
   localparam int unsigned T_SUPPLY_MS = 96;
   localparam int unsigned T_DOG_HOLD_US = 2048;
   localparam int unsigned T_SE0_US = 8;
   // Least times round up
   localparam int unsigned SETTLE_CYCLES =
      (T_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SUPPLY_CYCLES =
      (T_SUPPLY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DOG_HOLD_CYCLES =
      (T_DOG_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Strictly longer than the SE0 time
   localparam int unsigned SE0_CYCLES = (T_SE0_US * 1000) / CLK_PERIOD_NS + 1;
   localparam int unsigned CNT_W = 21;
   localparam int unsigned SE0_W = 9;
   localparam int unsigned DOG_W = 2;

   // ---------------------------------------------------------
   // I/O map and fields
   // ---------------------------------------------------------
   localparam logic [7:0] ADDR_USB_ADDR = 8'h10;
   localparam logic [7:0] ADDR_DOG_CLEAR = 8'h26;
   localparam logic [7:0] ADDR_STATUS = 8'hff;
   localparam int unsigned SB_RUN = 0;
   localparam int unsigned SB_STEP = 1;
   localparam int unsigned SB_IMASK = 2;
   localparam int unsigned SB_SUSP = 3;
   localparam int unsigned SB_POR = 4;
   localparam int unsigned SB_BUSRST = 5;
   localparam int unsigned SB_DOG = 6;
   localparam int unsigned SB_IRQ = 7;
   localparam int unsigned ADDR_EN_BIT = 7;
   localparam logic [7:0] STATUS_POR = 8'h11;
   localparam logic [7:0] STATUS_DOG = 8'h41;
   localparam logic [7:0] STATUS_WMASK = 8'h7b;
   localparam logic [7:0] USB_ADDR_RESET = 8'h00;
   localparam logic [7:0] STACK_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [13:0] PC_RESET = 14'h0000;

   // ---------------------------------------------------------
   // Types
   // ---------------------------------------------------------
   typedef enum logic [4:0] {
      RWC_HOLD = 5'h01,
      RWC_DOG = 5'h02,
      RWC_SLEEP = 5'h04,
      RWC_SETTLE = 5'h08,
      RWC_RUN = 5'h10
   } rwc_state_t;

   typedef struct packed {
      logic power_low;
      logic strap;
      logic usb_minus_line;
      logic usb_plus_line;
   } rwc_pins_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rwc_io_req_t;

   localparam rwc_pins_t PINS_RESET = 4'h8;

endpackage

// [design/rwc_top.sv]
module rwc_top #(
   parameter int unsigned SUPPLY_CYCLES = rwc_pkg::SUPPLY_CYCLES,
   parameter int unsigned DOG_HOLD_CYCLES = rwc_pkg::DOG_HOLD_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   // Raw pins, detector
   input wire rwc_pkg::rwc_pins_t PINS,
   // Free-running timer bit 11
   input wire logic TIMER_BIT11,
   input wire logic IRQ_PENDING,
   input wire logic INT_MASK,
   input wire logic HALT_REQ,
   input wire rwc_pkg::rwc_io_req_t IO_REQ,
   // Stack pointer writes
   input wire logic [1:0] SP_WE,
   input wire logic [7:0] SP_WDATA,
   output logic [7:0] IO_RDATA,
   output logic HW_RESET,
   output logic CPU_HOLD,
   output logic PC_LOAD,
   output logic [13:0] PC_VECTOR,
   output logic [7:0] PROG_STACK_PTR,
   output logic [7:0] DATA_STACK_PTR,
   output logic GPIO_HIZ,
   output logic INT_DISABLE,
   output logic [7:0] USB_ADDR,
   output logic USB_TX_ENABLE,
   output logic BUS_RESET_IRQ,
   output logic SUSPEND,
   output logic RUN,
   output logic SINGLE_STEP
);

   // ---------------------------------------------------------
   // Local constants
   // ---------------------------------------------------------
   localparam int unsigned CW = rwc_pkg::CNT_W;
   localparam logic [CW-1:0] LD_SETTLE = CW'(rwc_pkg::SETTLE_CYCLES - 1);
   localparam logic [CW-1:0] LD_SUPPLY = CW'(SUPPLY_CYCLES - 1);
   localparam logic [CW-1:0] LD_DOG = CW'(DOG_HOLD_CYCLES - 1);
   localparam logic [CW-1:0] CNT_ZERO = CW'(0);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);
   localparam int unsigned SW = rwc_pkg::SE0_W;
   localparam logic [SW-1:0] SE0_LAST = SW'(rwc_pkg::SE0_CYCLES - 1);
   localparam logic [SW-1:0] SE0_ONE = SW'(1);
   localparam logic [SW-1:0] SE0_ZERO = SW'(0);
   localparam int unsigned DW = rwc_pkg::DOG_W;
   localparam logic [DW-1:0] DOG_ZERO = DW'(0);

   // ---------------------------------------------------------
   // Functions
   // ---------------------------------------------------------
   // Start-up delay: strap first, then power-up flag
   function automatic logic [CW-1:0] delay_load(
      input logic strap,
      input logic power_up_flag
   );
      logic [CW-1:0] v;
      v = LD_SETTLE;
      if (!strap && power_up_flag) begin
         v = LD_SUPPLY;
      end
      return v;
   endfunction

   // Take a bit only once two stages agree
   function automatic logic [3:0] agree(
      input logic [3:0] a,
      input logic [3:0] b,
      input logic [3:0] keep
   );
      return (~(a ^ b) & a) | ((a ^ b) & keep);
   endfunction

   // ---------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------
   rwc_pkg::rwc_pins_t s1_q, s2_q, s3_q; // Sync chain
   rwc_pkg::rwc_pins_t pin_q; // Filtered pins
   rwc_pkg::rwc_pins_t pin_d;
   rwc_pkg::rwc_state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d; // Delay counter
   logic boot_q, boot_d; // Run from address zero
   logic [SW-1:0] se0_q, se0_d; // SE0 length
   logic bus_irq_q; // Bus reset pulse
   logic t11_q; // Timer bit history
   logic [DW-1:0] dog_q, dog_d; // Watchdog count
   logic [7:0] st_q, st_d; // Status/control
   logic [7:0] addr_q, addr_d; // USB device address
   logic [7:0] psp_q, dsp_q; // Stack pointers
   logic [7:0] rdata_q, rdata_d; // Read data
   logic pc_load_q, pc_load_d; // Entry pulse

   // ---------------------------------------------------------
   // Pin decode
   // ---------------------------------------------------------
   wire in_hold = (state_q == rwc_pkg::RWC_HOLD);
   wire in_dog = (state_q == rwc_pkg::RWC_DOG);
   wire in_sleep = (state_q == rwc_pkg::RWC_SLEEP);
   wire in_settle = (state_q == rwc_pkg::RWC_SETTLE);
   wire in_run = (state_q == rwc_pkg::RWC_RUN);
   wire hw_rst = in_hold | in_dog;
   // Line states
   wire line_idle = pin_q.usb_minus_line & ~pin_q.usb_plus_line;
   wire line_k = pin_q.usb_plus_line & ~pin_q.usb_minus_line;
   wire line_se0 = ~pin_q.usb_plus_line & ~pin_q.usb_minus_line;
   // SE0 outlasted the limit
   wire bus_rst_hit = line_se0 & (se0_q == SE0_LAST); // R20
   // I/O strobes
   wire wr_status = IO_REQ.wr & (IO_REQ.addr == rwc_pkg::ADDR_STATUS);
   wire wr_addr = IO_REQ.wr & (IO_REQ.addr == rwc_pkg::ADDR_USB_ADDR);
   // Data value is ignored
   wire dog_clr = IO_REQ.wr & (IO_REQ.addr == rwc_pkg::ADDR_DOG_CLEAR); // R17
   // Suspend refused while activity or an interrupt waits
   wire busy = line_k | line_se0 | IRQ_PENDING;
   wire sleep_req = in_run & wr_status & IO_REQ.wdata[rwc_pkg::SB_SUSP] & ~busy;
   // Wake events; interrupts only wake a firmware suspend
   wire wake = line_k | line_se0 | (~boot_q & IRQ_PENDING); // R10
   wire cnt_done = (cnt_q == CNT_ZERO);
   // One count per timer bit 11 period
   wire dog_tick = TIMER_BIT11 & ~t11_q; // R16
   wire dog_fire = in_run & ~dog_q[DW-1] & dog_d[DW-1]; // R15

   // ---------------------------------------------------------
   // Synchroniser
   // ---------------------------------------------------------
   // First stage feeds only the second; a bit moves once
   // the later two agree, so a glitch cannot start a reset
   assign pin_d = agree(s2_q, s3_q, pin_q); // R23

   // Four flops per pin: three sync stages and the filtered value
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         s1_q <= rwc_pkg::PINS_RESET;
         s2_q <= rwc_pkg::PINS_RESET;
         s3_q <= rwc_pkg::PINS_RESET;
         pin_q <= rwc_pkg::PINS_RESET;
      end else begin
         s1_q <= PINS;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d; // R23
      end
   end

   // ---------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------
   // Next state and delay counter
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      boot_d = boot_q;
      pc_load_d = 1'b0;
      unique case (state_q)
         // Power-on: held until the detector releases
         rwc_pkg::RWC_HOLD: begin
            boot_d = 1'b1;
            cnt_d = delay_load(pin_q.strap, 1'b1); // R12
            if (pin_q.strap && line_idle) begin
               state_d = rwc_pkg::RWC_SLEEP; // R10
            end else begin
               state_d = rwc_pkg::RWC_SETTLE; // R13
            end
         end
         // Watchdog hold time
         rwc_pkg::RWC_DOG: begin
            cnt_d = cnt_q - CNT_ONE;
            if (cnt_done) begin
               state_d = rwc_pkg::RWC_RUN; // R18
               pc_load_d = 1'b1; // R5
            end
         end
         // Parked until bus activity, or an interrupt after a firmware suspend
         rwc_pkg::RWC_SLEEP: begin
            if (wake) begin
               state_d = rwc_pkg::RWC_SETTLE; // R11
               cnt_d = delay_load(pin_q.strap, st_q[rwc_pkg::SB_POR]); // R13
            end
         end
         // Processor stopped while the clock or supply settles
         rwc_pkg::RWC_SETTLE: begin
            cnt_d = cnt_q - CNT_ONE;
            if (cnt_done) begin
               state_d = rwc_pkg::RWC_RUN;
               // Firmware suspend resumes in place, no entry
               pc_load_d = boot_q; // R5
               boot_d = 1'b0;
            end
         end
         // Normal execution
         rwc_pkg::RWC_RUN: begin
            if (dog_fire) begin
               state_d = rwc_pkg::RWC_DOG; // R15
               cnt_d = LD_DOG; // R18
            end else if (sleep_req) begin
               state_d = rwc_pkg::RWC_SLEEP;
               boot_d = 1'b0;
            end
         end
         default: begin
            state_d = rwc_pkg::RWC_HOLD;
         end
      endcase
      // Detector wins from any state
      if (pin_q.power_low) begin
         state_d = rwc_pkg::RWC_HOLD; // R1
      end
   end

   // State flops
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_q <= rwc_pkg::RWC_HOLD;
         cnt_q <= CNT_ZERO;
         boot_q <= 1'b1;
         pc_load_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         boot_q <= boot_d;
         pc_load_q <= pc_load_d;
      end
   end

   // ---------------------------------------------------------
   // Watchdog and bus reset detector
   // ---------------------------------------------------------
   // Clear and tick in one cycle: tick survives
   assign dog_d = in_run ? ((dog_clr ? DOG_ZERO : dog_q) + DW'(dog_tick)) : DOG_ZERO;

   // SE0 length count; parks one past the limit so a long SE0 flags once
   assign se0_d = !line_se0 ? SE0_ZERO :
                  (se0_q > SE0_LAST) ? se0_q : se0_q + SE0_ONE;

   // Counters and edge history
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         dog_q <= DOG_ZERO;
         t11_q <= 1'b0;
         se0_q <= SE0_ZERO;
         bus_irq_q <= 1'b0;
      end else begin
         dog_q <= dog_d; // R16
         t11_q <= TIMER_BIT11;
         se0_q <= se0_d;
         // Interrupt only; processor keeps running
         bus_irq_q <= bus_rst_hit; // R20
      end
   end

   // ---------------------------------------------------------
   // Status and address registers
   // ---------------------------------------------------------
   // Status next value; hardware set beats firmware write
   always_comb begin
      st_d = st_q;
      if (in_hold) begin
         st_d = rwc_pkg::STATUS_POR; // R21
      end else if (in_dog) begin
         st_d = rwc_pkg::STATUS_DOG; // R22
      end else begin
         if (wr_status) begin
            st_d = (st_q & ~rwc_pkg::STATUS_WMASK) |
                   (IO_REQ.wdata & rwc_pkg::STATUS_WMASK); // R4
            // Refused suspend request leaves the bit low
            st_d[rwc_pkg::SB_SUSP] = sleep_req;
         end
         // Wake clears the suspend bit
         if (in_sleep && wake) begin
            st_d[rwc_pkg::SB_SUSP] = 1'b0;
         end
         if (HALT_REQ) begin
            st_d[rwc_pkg::SB_RUN] = 1'b0;
         end
         if (bus_rst_hit) begin
            st_d[rwc_pkg::SB_BUSRST] = 1'b1; // R20
         end
      end
      // Live bits are never stored
      st_d[rwc_pkg::SB_IRQ] = 1'b0;
      st_d[rwc_pkg::SB_IMASK] = 1'b0;
   end

   // Address register, cleared by either reset kind
   always_comb begin
      addr_d = addr_q;
      if (wr_addr) begin
         addr_d = IO_REQ.wdata;
      end
      if (hw_rst || bus_rst_hit) begin
         addr_d = rwc_pkg::USB_ADDR_RESET; // R2
      end
   end

   // Read mux, registered below
   always_comb begin
      rdata_d = rdata_q;
      if (IO_REQ.rd) begin
         rdata_d = rwc_pkg::RDATA_RESET;
         if (IO_REQ.addr == rwc_pkg::ADDR_STATUS) begin
            rdata_d = {IRQ_PENDING, st_q[6:3], INT_MASK, st_q[1:0]}; // R4
         end else if (IO_REQ.addr == rwc_pkg::ADDR_USB_ADDR) begin
            rdata_d = addr_q;
         end
      end
   end

   // Register flops
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         st_q <= rwc_pkg::STATUS_POR; // R8
         addr_q <= rwc_pkg::USB_ADDR_RESET;
         rdata_q <= rwc_pkg::RDATA_RESET;
      end else begin
         st_q <= st_d;
         addr_q <= addr_d;
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------
   // Stack pointers
   // ---------------------------------------------------------
   // Zeroed by reset; entry pushes nothing, so firmware
   // must not return from the reset handler
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         psp_q <= rwc_pkg::STACK_RESET;
         dsp_q <= rwc_pkg::STACK_RESET;
      end else if (hw_rst) begin
         psp_q <= rwc_pkg::STACK_RESET; // R3
         dsp_q <= rwc_pkg::STACK_RESET; // R3
      end else begin
         if (SP_WE[0]) begin
            psp_q <= SP_WDATA;
         end
         if (SP_WE[1]) begin
            dsp_q <= SP_WDATA;
         end
      end
   end

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   // Only power-on and watchdog reset the core
   assign HW_RESET = hw_rst; // R1
   assign INT_DISABLE = hw_rst; // R2
   assign CPU_HOLD = ~in_run; // R11
   // Pins float only while the power-on hold lasts
   assign GPIO_HIZ = in_hold; // R9
   // Vector load only; no stack push request exists
   assign PC_LOAD = pc_load_q; // R6
   assign PC_VECTOR = rwc_pkg::PC_RESET; // R5
   assign PROG_STACK_PTR = psp_q;
   assign DATA_STACK_PTR = dsp_q;
   assign IO_RDATA = rdata_q;
   assign USB_ADDR = addr_q;
   // Silent until firmware enables the address
   assign USB_TX_ENABLE = addr_q[rwc_pkg::ADDR_EN_BIT] & ~hw_rst; // R19
   assign BUS_RESET_IRQ = bus_irq_q;
   assign SUSPEND = in_sleep;
   assign RUN = st_q[rwc_pkg::SB_RUN];
   assign SINGLE_STEP = st_q[rwc_pkg::SB_STEP];
   wire unused_settle = in_settle;

endmodule

// [dv/rwc_top_properties.sv]
// ---------------------------------------------------------
// Port-level checks of reset and watchdog sequencing
// ---------------------------------------------------------
module rwc_top_properties (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic HW_RESET,
   input wire logic CPU_HOLD,
   input wire logic PC_LOAD,
   input wire logic [13:0] PC_VECTOR,
   input wire logic [7:0] PROG_STACK_PTR,
   input wire logic [7:0] DATA_STACK_PTR,
   input wire logic GPIO_HIZ,
   input wire logic INT_DISABLE,
   input wire logic [7:0] USB_ADDR,
   input wire logic USB_TX_ENABLE,
   input wire logic BUS_RESET_IRQ,
   input wire logic SUSPEND
);
   timeunit 1ns;
   timeprecision 1ns;
   // One domain, so one default clock and disable
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);

   // Any hold lasts well beyond a few cycles
   sequence s_hold;
      HW_RESET [*8];
   endsequence

   // Pulse outside reset, gone next cycle
   sequence s_pulse_end(sig);
      !HW_RESET ##1 !sig;
   endsequence

   property p_int_off; INT_DISABLE == HW_RESET; endproperty
   property p_hold_len; $rose(HW_RESET) |-> s_hold; endproperty
   property p_stack; HW_RESET |=> PROG_STACK_PTR == 8'h00 && DATA_STACK_PTR == 8'h00; endproperty
   property p_addr; HW_RESET |=> USB_ADDR == 8'h00; endproperty
   property p_tx; USB_TX_ENABLE == (USB_ADDR[7] && !HW_RESET); endproperty
   property p_hiz; GPIO_HIZ |-> HW_RESET && CPU_HOLD; endproperty
   property p_vec; PC_VECTOR == 14'h0000; endproperty
   property p_pc; PC_LOAD |-> s_pulse_end(PC_LOAD); endproperty
   property p_irq; BUS_RESET_IRQ |-> s_pulse_end(BUS_RESET_IRQ); endproperty
   property p_susp; SUSPEND |-> CPU_HOLD; endproperty

   a_int_off: assert property (p_int_off) else $error("interrupts not off in reset");
   a_hold_len: assert property (p_hold_len) else $error("reset hold too short");
   a_stack: assert property (p_stack) else $error("stack pointer not zero");
   a_addr: assert property (p_addr) else $error("usb address not zero");
   a_tx: assert property (p_tx) else $error("transmitter enable wrong");
   a_hiz: assert property (p_hiz) else $error("pins floated outside hold");
   a_vec: assert property (p_vec) else $error("start address not zero");
   a_pc: assert property (p_pc) else $error("bad start pulse");
   a_irq: assert property (p_irq) else $error("bad bus reset pulse");
   a_susp: assert property (p_susp) else $error("cpu runs in suspend");
endmodule

bind rwc_top rwc_top_properties i_rwc_top_properties (
   .CORE_CLK(CORE_CLK), .RST(RST), .HW_RESET(HW_RESET), .CPU_HOLD(CPU_HOLD),
   .PC_LOAD(PC_LOAD), .PC_VECTOR(PC_VECTOR), .PROG_STACK_PTR(PROG_STACK_PTR),
   .DATA_STACK_PTR(DATA_STACK_PTR), .GPIO_HIZ(GPIO_HIZ), .INT_DISABLE(INT_DISABLE),
   .USB_ADDR(USB_ADDR), .USB_TX_ENABLE(USB_TX_ENABLE), .BUS_RESET_IRQ(BUS_RESET_IRQ),
   .SUSPEND(SUSPEND)
);

// [dv/rwc_top_test.sv]
module rwc_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------
   localparam int unsigned SUP = 50; // Short supply wait keeps run brief
   localparam int unsigned HOLD = 20; // Short watchdog hold
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   rwc_pkg::rwc_pins_t pins = 4'h2; // Supply good, strap low, bus idle
   logic timer_bit11 = 1'b0;
   rwc_pkg::rwc_io_req_t io_req = '0;
   logic [1:0] sp_we = 2'h0;
   logic [7:0] sp_wdata = 8'h00;
   logic [7:0] io_rdata, program_stack_pointer, dsp, usb_addr, rd, r;
   logic hw_reset, cpu_hold, pc_load, gpio_hiz, usb_tx, bus_irq, suspend, run_bit, step_bit;
   int error_cnt = 0;
   int checks_done = 0;
   int seed = 32'h3e41;
   int unsigned n;

   // Free-running core clock
   always #25 core_clk = ~core_clk;

   // Interrupt inputs tied idle: no interrupt logic here
   rwc_top #(.SUPPLY_CYCLES(SUP), .DOG_HOLD_CYCLES(HOLD)) i_rwc_top (
      .CORE_CLK(core_clk), .RST(rst), .PINS(pins), .TIMER_BIT11(timer_bit11),
      .IRQ_PENDING(1'b0), .INT_MASK(1'b0), .HALT_REQ(1'b0), .IO_REQ(io_req),
      .SP_WE(sp_we), .SP_WDATA(sp_wdata), .IO_RDATA(io_rdata), .HW_RESET(hw_reset),
      .CPU_HOLD(cpu_hold), .PC_LOAD(pc_load), .PC_VECTOR(), .PROG_STACK_PTR(program_stack_pointer),
      .DATA_STACK_PTR(dsp), .GPIO_HIZ(gpio_hiz), .INT_DISABLE(), .USB_ADDR(usb_addr),
      .USB_TX_ENABLE(usb_tx), .BUS_RESET_IRQ(bus_irq), .SUSPEND(suspend), .RUN(run_bit),
      .SINGLE_STEP(step_bit)
   );

   // ---------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------
   // Expected start-up wait in cycles
   function automatic int unsigned exp_delay(input logic strap, input logic por);
      return (strap || !por) ? rwc_pkg::SETTLE_CYCLES : SUP;
   endfunction

   task automatic chk(input logic ok, input string msg);
      checks_done++;
      // An unknown result counts as a mismatch
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   // One bus cycle; extra cycle lets a write land
   task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      io_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk);
      io_req <= '0;
      @(negedge core_clk);
      rd = io_rdata;
      @(negedge core_clk);
   endtask

   // One rising edge of timer bit 11
   task automatic tick();
      @(posedge core_clk);
      timer_bit11 <= 1'b1;
      repeat (2) @(posedge core_clk);
      timer_bit11 <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   // Counts cycles until the cpu is let go, bounded
   task automatic until_run(input int unsigned lim);
      n = 0;
      while (cpu_hold !== 1'b0 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   // Window allows for pin synchronisers
   task automatic win(input int unsigned lo);
      chk(n >= lo && n <= lo + 12, "start-up wait");
   endtask

   task automatic pc_chk();
      n = 0;
      while (pc_load !== 1'b1 && n < 3) begin
         @(negedge core_clk);
         n++;
      end
      chk(pc_load === 1'b1, "no start pulse");
   endtask

   task automatic boot(input rwc_pkg::rwc_pins_t p, input int unsigned lim);
      @(posedge core_clk);
      rst <= 1'b1;
      pins <= p;
      repeat (16) @(posedge core_clk);
      chk(hw_reset === 1'b1 && gpio_hiz === 1'b1 && cpu_hold === 1'b1, "hold");
      chk({program_stack_pointer, dsp, usb_addr} === 24'h0, "regs not cleared");
      rst <= 1'b0;
      until_run(lim);
   endtask

   task automatic end_of_test();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ---------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------
   initial begin
      // Strap low power-on: supply wait, shortened here to SUP cycles
      boot(4'h2, 400);
      win(exp_delay(1'b0, 1'b1));
      pc_chk();
      io(1'b0, rwc_pkg::ADDR_STATUS, 8'h00);
      chk(rd === rwc_pkg::STATUS_POR && run_bit === 1'b1 && step_bit === 1'b0, "power-on status");
      io(1'b0, rwc_pkg::ADDR_DOG_CLEAR, 8'h00);
      chk(rd === 8'h00, "clear port readable");
      // Suspend with power-up flag kept: SUP supply wait on wake
      io(1'b1, rwc_pkg::ADDR_STATUS, 8'h19);
      chk(suspend === 1'b1, "no suspend");
      @(posedge core_clk);
      pins <= 4'h1;
      until_run(400);
      win(exp_delay(1'b0, 1'b1));
      @(posedge core_clk);
      pins <= 4'h2;
      // Random stack and address values, data stack kept below the buffers
      r = 8'($random(seed)) % 8'he8;
      @(posedge core_clk);
      sp_we <= 2'h3;
      sp_wdata <= r;
      @(posedge core_clk);
      sp_we <= 2'h0;
      io(1'b1, rwc_pkg::ADDR_USB_ADDR, r | 8'h80);
      chk(usb_tx === 1'b1 && program_stack_pointer === r && dsp === r, "transmitter on");
      // Cleared after every tick: never fires
      for (int i = 0; i < 16; i++) begin
         tick();
         io(1'b1, rwc_pkg::ADDR_DOG_CLEAR, 8'($random(seed)));
      end
      chk(hw_reset === 1'b0, "cleared watchdog fired");
      tick();
      chk(hw_reset === 1'b0, "fired on first tick");
      tick();
      chk(hw_reset === 1'b1, "watchdog not fired");
      io(1'b0, rwc_pkg::ADDR_STATUS, 8'h00);
      chk(rd === rwc_pkg::STATUS_DOG, "watchdog status");
      chk({program_stack_pointer, dsp, usb_addr, usb_tx} === 25'h0, "watchdog clear");
      until_run(HOLD + 10);
      chk(cpu_hold === 1'b0, "stuck in watchdog hold");
      pc_chk();
      // Long single-ended zero on the bus
      io(1'b1, rwc_pkg::ADDR_USB_ADDR, 8'h85);
      @(posedge core_clk);
      pins <= 4'h0;
      n = 0;
      while (bus_irq !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      chk(n >= 162 && n <= 172 && hw_reset === 1'b0, "bus reset timing");
      @(posedge core_clk);
      pins <= 4'h2;
      io(1'b0, rwc_pkg::ADDR_STATUS, 8'h00);
      chk(rd[5] === 1'b1 && usb_addr === 8'h00 && cpu_hold === 1'b0, "bus reset");
      // Suspend with power-up flag cleared: settle wait, longer than SUP here
      io(1'b1, rwc_pkg::ADDR_STATUS, 8'h09);
      chk(suspend === 1'b1, "no suspend");
      @(posedge core_clk);
      pins <= 4'h1;
      until_run(3000);
      win(exp_delay(1'b0, 1'b0));
      // Strap high power-on with idle bus parks
      boot(4'h6, 200);
      chk(suspend === 1'b1 && cpu_hold === 1'b1, "not parked");
      @(posedge core_clk);
      pins <= 4'h5;
      until_run(3000);
      win(exp_delay(1'b1, 1'b1));
      pc_chk();
      end_of_test();
   end

   // Hang guard, well past the expected run
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      end_of_test();
   end
endmodule
